//--- rtl/standby_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          standby entry and wake controller.
// Assumes: 32-bit byte addresses on the register port.
// Notes:   Definitions only.
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH

`define ADDR_EDGE_CTL     32'h0FFF8358
`define ADDR_WDT_CSR      32'hFFFF8610
`define ADDR_STBY_CTL     32'hFFFF8614
`define ADDR_STAB_CNT     32'hFFFF8618
`define ADDR_STBY_STAT    32'hFFFF861C

`define SBY_SELECT_BIT    7
`define SBY_FLOAT_BIT     6
`define SBY_UPPER_BIT     1
`define SBY_LOWER_BIT     0
`define WDT_MODE_BIT      6
`define WDT_RUN_BIT       5
`define WDT_CKS_MSB       2
`define WDT_CKS_LSB       0
`define ICR_EDGE_BIT      8
`define ICR_LEVEL_BIT     15
`define STAT_REFUSED_BIT  4

`define STBY_CTL_RST      4'h0
`define WDT_CSR_RST       5'h00
`define EDGE_SEL_RST      1'b0
`define STAB_CNT_RST      8'h00

`define CNT_MAX           8'hFF
// Division exponent is clock select code plus this base; code 6 -> 1/4096.
`define DIV_EXP_BASE      6
`define CKS_DIV4096       3'h6

`endif

//--- rtl/standby_pkg.sv
// Purpose: Types shared by the standby entry and wake controller.
// Assumes: Constants come from standby_defs.svh.
// Notes:   Types only.
package standby_pkg;

  typedef enum logic [3:0] {
    ST_RUN       = 4'h1,
    ST_SLEEP     = 4'h2,
    ST_STANDBY   = 4'h4,
    ST_STABILIZE = 4'h8
  } standby_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic standby_select;
    logic pin_float_select;
    logic upper_irq_wake_control;
    logic lower_irq_wake_control;
  } standby_control_s;

  typedef struct packed {
    logic       timer_mode_select;
    logic       timer_run_enable;
    logic [2:0] timer_clock_select;
  } watchdog_control_s;

  typedef struct packed {
    logic osc_run;
    logic chip_clk_en;
    logic cpu_sleep;
    logic hold_pins;
    logic float_pins;
  } power_ctl_s;

endpackage : standby_pkg

//--- rtl/pin_input_filter.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Pins are asynchronous to core_clk_in.
// Notes:   A change is taken once the second and third stages agree.
`timescale 1ns/10ps
module pin_input_filter #(
  parameter int WIDTH = 9
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] agree_reg;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_reg[i]  <= 1'b0;
        sync_reg[i]  <= 1'b0;
        agree_reg[i] <= 1'b0;
        level_out[i] <= 1'b0;
      end else if (clk_en_in) begin
        meta_reg[i]  <= pin_in[i];
        sync_reg[i]  <= meta_reg[i];
        agree_reg[i] <= sync_reg[i];
        // A single-cycle disagreement is a glitch and is not passed on.
        if (sync_reg[i] == agree_reg[i]) begin
          level_out[i] <= agree_reg[i];
        end
      end
    end
  end

endmodule : pin_input_filter

//--- rtl/standby_entry_wake_control.sv
// Purpose: Software standby entry, wake-up and oscillator stabilisation.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Clock gating itself lives outside; this block drives enables.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "standby_defs.svh"
module standby_entry_wake_control
  import standby_pkg::*;
#(
  parameter int DIV_EXP_BASE = `DIV_EXP_BASE
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       clk_en_in,
  input  wire bus_req_s   bus_req_in,
  output logic [31:0]     rdata_out,
  input  wire logic       sleep_exec_in,
  input  wire logic       nmi_pin_in,
  input  wire logic [7:0] irq_pin_in,
  output power_ctl_s      power_out,
  output logic            nmi_exception_out,
  output logic            interval_ovf_out,
  output logic            wdt_reset_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  standby_state_e    state_reg;
  standby_control_s  standby_control_reg;
  watchdog_control_s watchdog_control_status_reg;
  logic              nonmaskable_edge_select_reg;
  logic [7:0]        stabilization_counter_reg;
  logic              refused_reg;
  logic              wake_by_pin_reg;
  logic              pin_prev_reg;
  logic [13:0]       prescale_reg;
  logic [8:0]        pin_level;
  logic              nonmaskable_pin_level;
  logic [7:0]        irq_level;
  logic              pin_rise;
  logic              pin_fall;
  logic              pin_edge;
  logic              wake_evt;
  logic              upper_wake;
  logic              lower_wake;
  logic              sleep_std;
  logic              count_en;
  logic [4:0]        div_exp;
  logic [13:0]       div_mask;
  logic              tick;
  logic              cnt_ovf;
  logic              wr_ok;
  logic              in_standby;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  pin_input_filter #(
    .WIDTH (9)
  ) u_pins (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .pin_in      ({~nmi_pin_in, irq_pin_in}),
    .level_out   (pin_level)
  );

  // The pin idles high, so it is filtered inverted: no false edge at reset.
  assign nonmaskable_pin_level = ~pin_level[8];
  assign irq_level             = pin_level[7:0];

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev_reg <= 1'b1;
    end else if (clk_en_in) begin
      pin_prev_reg <= nonmaskable_pin_level;
    end
  end

  assign pin_rise = nonmaskable_pin_level & ~pin_prev_reg;
  assign pin_fall = ~nonmaskable_pin_level & pin_prev_reg;
  assign pin_edge = nonmaskable_edge_select_reg ? pin_rise : pin_fall;

  // Polarity as printed: a one in the control bit blocks that group.
  assign upper_wake = (|irq_level[7:4]) &
                      ~standby_control_reg.upper_irq_wake_control;
  assign lower_wake = (|irq_level[3:0]) &
                      ~standby_control_reg.lower_irq_wake_control;
  assign wake_evt   = pin_edge | upper_wake | lower_wake;

  ////////////////////////////////////////////////////////////////////////
  // Standby sequencer.

  assign in_standby = (state_reg == ST_STANDBY) ||
                      (state_reg == ST_STABILIZE);
  assign sleep_std  = (state_reg == ST_RUN) && sleep_exec_in &&
                      standby_control_reg.standby_select;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_RUN;
    end else if (clk_en_in) begin
      case (state_reg)
        ST_RUN: begin
          if (sleep_exec_in) begin
            if (!standby_control_reg.standby_select) begin
              state_reg <= ST_SLEEP;
            end else if (!watchdog_control_status_reg.timer_run_enable) begin
              state_reg <= ST_STANDBY;
            end
          end
        end
        ST_SLEEP: begin
          if (pin_edge || (|irq_level)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_STANDBY: begin
          if (wake_evt) begin
            state_reg <= ST_STABILIZE;
          end
        end
        ST_STABILIZE: begin
          if (cnt_ovf) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // Remember whether the pin edge caused the wake, for the exception.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_by_pin_reg <= 1'b0;
    end else if (clk_en_in && state_reg == ST_STANDBY && wake_evt) begin
      wake_by_pin_reg <= pin_edge;
    end
  end

  // Set wins over a clear in the same cycle, so no refusal is missed.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      refused_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (sleep_std && watchdog_control_status_reg.timer_run_enable) begin
        refused_reg <= 1'b1;
      end else if (wr_ok && bus_req_in.addr == `ADDR_STBY_STAT &&
                   bus_req_in.wdata[`STAT_REFUSED_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // The oscillator stays off only in full standby; pins follow the
  // float select until the chip clock returns.
  always_comb begin
    power_out.osc_run     = (state_reg != ST_STANDBY);
    power_out.chip_clk_en = (state_reg == ST_RUN);
    power_out.cpu_sleep   = (state_reg == ST_SLEEP);
    power_out.hold_pins   = in_standby &
                            ~standby_control_reg.pin_float_select;
    power_out.float_pins  = in_standby &
                            standby_control_reg.pin_float_select;
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and stabilisation counter.

  assign count_en = ((state_reg == ST_RUN) &&
                     watchdog_control_status_reg.timer_run_enable) ||
                    (state_reg == ST_STABILIZE);
  assign div_exp  = 5'(watchdog_control_status_reg.timer_clock_select) +
                    5'(DIV_EXP_BASE);
  assign div_mask = 14'((15'h0001 << div_exp) - 15'h0001);
  assign tick     = count_en && ((prescale_reg & div_mask) == div_mask);
  assign cnt_ovf  = tick && (stabilization_counter_reg == `CNT_MAX);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_reg <= 14'h0000;
    end else if (clk_en_in && count_en) begin
      prescale_reg <= prescale_reg + 14'h0001;
    end
  end

  // Software writes only land while running; standby keeps the value.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stabilization_counter_reg <= `STAB_CNT_RST;
    end else if (clk_en_in) begin
      if (wr_ok && bus_req_in.addr == `ADDR_STAB_CNT) begin
        stabilization_counter_reg <= bus_req_in.wdata[7:0];
      end else if (tick) begin
        stabilization_counter_reg <= stabilization_counter_reg + 8'h01;
      end
    end
  end

  // Pulses also freeze while the clock enable is low.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_exception_out <= 1'b0;
      interval_ovf_out  <= 1'b0;
      wdt_reset_out     <= 1'b0;
    end else if (clk_en_in) begin
      nmi_exception_out <= (pin_edge && (state_reg == ST_RUN ||
                                         state_reg == ST_SLEEP)) ||
                           (state_reg == ST_STABILIZE && cnt_ovf &&
                            wake_by_pin_reg);
      interval_ovf_out  <= (state_reg == ST_RUN) && cnt_ovf &&
                           !watchdog_control_status_reg.timer_mode_select;
      wdt_reset_out     <= (state_reg == ST_RUN) && cnt_ovf &&
                           watchdog_control_status_reg.timer_mode_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port.

  // The CPU is stopped outside the run state, so writes there are dropped.
  assign wr_ok = bus_req_in.wr && (state_reg == ST_RUN);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_control_reg         <= `STBY_CTL_RST;
      watchdog_control_status_reg <= `WDT_CSR_RST;
      nonmaskable_edge_select_reg <= `EDGE_SEL_RST;
    end else if (clk_en_in && wr_ok) begin
      if (bus_req_in.addr == `ADDR_STBY_CTL) begin
        standby_control_reg <= {bus_req_in.wdata[`SBY_SELECT_BIT],
                                bus_req_in.wdata[`SBY_FLOAT_BIT],
                                bus_req_in.wdata[`SBY_UPPER_BIT],
                                bus_req_in.wdata[`SBY_LOWER_BIT]};
      end else if (bus_req_in.addr == `ADDR_WDT_CSR) begin
        watchdog_control_status_reg <=
          {bus_req_in.wdata[`WDT_MODE_BIT],
           bus_req_in.wdata[`WDT_RUN_BIT],
           bus_req_in.wdata[`WDT_CKS_MSB:`WDT_CKS_LSB]};
      end else if (bus_req_in.addr == `ADDR_EDGE_CTL) begin
        nonmaskable_edge_select_reg <= bus_req_in.wdata[`ICR_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (clk_en_in) begin
      rdata_out <= 32'h00000000;
      if (bus_req_in.rd) begin
        if (bus_req_in.addr == `ADDR_STBY_CTL) begin
          rdata_out[`SBY_SELECT_BIT] <= standby_control_reg.standby_select;
          rdata_out[`SBY_FLOAT_BIT]  <= standby_control_reg.pin_float_select;
          rdata_out[`SBY_UPPER_BIT]  <=
            standby_control_reg.upper_irq_wake_control;
          rdata_out[`SBY_LOWER_BIT]  <=
            standby_control_reg.lower_irq_wake_control;
        end else if (bus_req_in.addr == `ADDR_WDT_CSR) begin
          rdata_out[`WDT_MODE_BIT] <=
            watchdog_control_status_reg.timer_mode_select;
          rdata_out[`WDT_RUN_BIT]  <=
            watchdog_control_status_reg.timer_run_enable;
          rdata_out[`WDT_CKS_MSB:`WDT_CKS_LSB] <=
            watchdog_control_status_reg.timer_clock_select;
        end else if (bus_req_in.addr == `ADDR_EDGE_CTL) begin
          rdata_out[`ICR_LEVEL_BIT] <= nonmaskable_pin_level;
          rdata_out[`ICR_EDGE_BIT]  <= nonmaskable_edge_select_reg;
        end else if (bus_req_in.addr == `ADDR_STAB_CNT) begin
          rdata_out[7:0] <= stabilization_counter_reg;
        end else if (bus_req_in.addr == `ADDR_STBY_STAT) begin
          rdata_out[3:0]               <= state_reg;
          rdata_out[`STAT_REFUSED_BIT] <= refused_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_standby_entry: assert property (
    clk_en_in && sleep_std &&
    !watchdog_control_status_reg.timer_run_enable
    |=> state_reg == ST_STANDBY && !power_out.osc_run)
    else $error("sleep with standby select did not enter standby");

  a_pin_hold: assert property (
    in_standby && !standby_control_reg.pin_float_select
    |-> power_out.hold_pins && !power_out.float_pins)
    else $error("pins not held during standby");

  a_upper_wake: assert property (
    clk_en_in && state_reg == ST_STANDBY && (|irq_level[7:4]) &&
    !standby_control_reg.upper_irq_wake_control
    |=> state_reg == ST_STABILIZE)
    else $error("enabled upper lines did not wake");

  a_lower_block: assert property (
    clk_en_in && state_reg == ST_STANDBY && !pin_edge && !upper_wake &&
    standby_control_reg.lower_irq_wake_control
    |=> state_reg == ST_STANDBY)
    else $error("blocked lower lines woke the device");

  a_timer_halt: assert property (
    clk_en_in && state_reg == ST_RUN &&
    !watchdog_control_status_reg.timer_run_enable && !bus_req_in.wr
    |=> $stable(stabilization_counter_reg))
    else $error("counter moved while run enable was low");

  a_interval_mode: assert property (
    clk_en_in && state_reg == ST_RUN && cnt_ovf &&
    !watchdog_control_status_reg.timer_mode_select
    |=> interval_ovf_out && !wdt_reset_out)
    else $error("interval mode overflow misreported");

  a_div_4096: assert property (
    tick && watchdog_control_status_reg.timer_clock_select == `CKS_DIV4096
    |-> &prescale_reg[DIV_EXP_BASE+5:0])
    else $error("1/4096 tick at wrong prescaler phase");

  a_edge_select: assert property (
    clk_en_in && state_reg == ST_RUN && !nonmaskable_edge_select_reg &&
    $fell(nonmaskable_pin_level) |=> nmi_exception_out)
    else $error("falling edge not taken");

  a_pin_level: assert property (
    clk_en_in && bus_req_in.rd && bus_req_in.addr == `ADDR_EDGE_CTL
    |=> rdata_out[`ICR_LEVEL_BIT] == $past(nonmaskable_pin_level))
    else $error("pin level bit wrong");

  a_sleep_refused: assert property (
    clk_en_in && sleep_std &&
    watchdog_control_status_reg.timer_run_enable
    |=> state_reg == ST_RUN && refused_reg)
    else $error("standby entered with timer running");

  a_overflow_wake: assert property (
    clk_en_in && state_reg == ST_STABILIZE && cnt_ovf
    |=> state_reg == ST_RUN && stabilization_counter_reg == 8'h00)
    else $error("overflow did not restore clocks");

  a_exception_wake: assert property (
    clk_en_in && state_reg == ST_STABILIZE && cnt_ovf && wake_by_pin_reg
    |=> nmi_exception_out && power_out.chip_clk_en)
    else $error("no exception after pin wake");

  a_standby_retain: assert property (
    state_reg == ST_STANDBY |=> $stable(stabilization_counter_reg) &&
    $stable(watchdog_control_status_reg))
    else $error("state changed during standby");

  c_refused: cover property (clk_en_in && sleep_std &&
    watchdog_control_status_reg.timer_run_enable);
  c_pin_wake: cover property (state_reg == ST_STABILIZE && cnt_ovf &&
    wake_by_pin_reg);
  c_irq_wake: cover property (state_reg == ST_STANDBY && !pin_edge &&
    wake_evt);
  c_wdt_reset: cover property (wdt_reset_out);

endmodule : standby_entry_wake_control

//--- verification/wake_switch_model.sv
// Purpose: Wake switch on the non-maskable pin, as the far side sees it.
// Assumes: Switch to ground with a pull-up on the pin.
// Notes:   Bounce count is chosen by the bench, 0 for a clean contact.
`timescale 1ns/10ps
module wake_switch_model (
  input  wire logic       press_in,
  input  wire logic [1:0] bounce_in,
  output logic            level_out
);
  // The pin has a pull-up, so a released switch reads high.
  initial level_out = 1'b1;
  // Bounce stays inside one core clock period, so at most one sample can
  // catch a wrong level; longer bounce would need a real debouncer.
  always @(press_in) begin
    level_out = ~press_in;
    for (int i = 0; i < 2 * bounce_in; i++) begin
      #13 level_out = ~level_out;
    end
  end
endmodule : wake_switch_model

//--- verification/test_standby_entry_wake_control.sv
// Purpose: Self-checking bench for the standby entry and wake controller.
// Assumes: DIV_EXP_BASE set to 0, so clock select code k ticks every 2^k.
// Notes:   Power outputs are compared as one packed word.
`timescale 1ns/10ps
`include "standby_defs.svh"
module test_standby_entry_wake_control
  import standby_pkg::*;
;
  logic        core_clk_in   = 1'b0;
  logic        rst_in        = 1'b1;
  logic        clk_en_in     = 1'b1;
  logic        sleep_exec_in = 1'b0;
  logic        press         = 1'b0;
  logic [1:0]  bounce        = 2'h0;
  logic [7:0]  irq_pin       = 8'h00;
  bus_req_s    bus_req       = '0;
  logic        nmi_pin;
  logic [31:0] rdata;
  power_ctl_s  power;
  logic        nmi_exc;
  logic        ivl_ovf;
  logic        wdt_rst;
  int          bad_count     = 0;
  int          num_checks    = 0;
  int          exc_count     = 0;
  int          rst_count     = 0;
  logic [31:0] seed          = 32'hEE5D;
  logic [31:0] d;
  logic [7:0]  v;
  int          n;
  int          e;
  int          idx;

  always #50 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    if (nmi_exc === 1'b1) exc_count++;
    if (wdt_rst === 1'b1) rst_count++;
  end

  standby_entry_wake_control #(.DIV_EXP_BASE(0)) u_dut (
    .core_clk_in      (core_clk_in),
    .rst_in           (rst_in),
    .clk_en_in        (clk_en_in),
    .bus_req_in       (bus_req),
    .rdata_out        (rdata),
    .sleep_exec_in    (sleep_exec_in),
    .nmi_pin_in       (nmi_pin),
    .irq_pin_in       (irq_pin),
    .power_out        (power),
    .nmi_exception_out(nmi_exc),
    .interval_ovf_out (ivl_ovf),
    .wdt_reset_out    (wdt_rst)
  );

  wake_switch_model u_switch (
    .press_in (press),
    .bounce_in(bounce),
    .level_out(nmi_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  function automatic int wake_cycles(input logic [7:0] start,
                                     input int code);
    return (256 - start) << code;
  endfunction : wake_cycles

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk_in);
    bus_req.addr  <= a;
    bus_req.wdata <= wd;
    bus_req.wr    <= 1'b1;
    @(posedge core_clk_in);
    bus_req.wr    <= 1'b0;
  endtask : bus_wr

  task automatic expect_reg(input string what, input logic [31:0] a,
                            input logic [31:0] exp);
    @(posedge core_clk_in);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge core_clk_in);
    bus_req.rd   <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : expect_reg

  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk_in);
    #1;
  endtask : cycles

  task automatic sleep_now();
    @(posedge core_clk_in);
    sleep_exec_in <= 1'b1;
    @(posedge core_clk_in);
    sleep_exec_in <= 1'b0;
    #1;
  endtask : sleep_now

  // Bounded wait so a lost wake-up shows as a mismatch, not a hang.
  task automatic wait_run(input int lim, output int cnt);
    cnt = 0;
    while (power.chip_clk_en !== 1'b1 && cnt < lim) begin
      @(posedge core_clk_in);
      #1 cnt++;
    end
  endtask : wait_run

  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    cycles(8);
    expect_reg("wdt_reset", `ADDR_WDT_CSR, 32'h00);
    expect_reg("stby_reset", `ADDR_STBY_CTL, 32'h00);
    expect_reg("state_reset", `ADDR_STBY_STAT, 32'h01);
    expect_reg("pin_high", `ADDR_EDGE_CTL, 32'h8000);
    bus_wr(`ADDR_STBY_CTL + 32'h10, 32'hFFFFFFFF);
    expect_reg("unmapped", `ADDR_STBY_CTL + 32'h10, 32'h00);
    bus_wr(`ADDR_STBY_CTL, 32'hFFFFFFFF);
    expect_reg("stby_rw", `ADDR_STBY_CTL, 32'hC3);
    bus_wr(`ADDR_STBY_CTL, 32'h00);
    // Edge select 0 then 1; bounce must never add exceptions.
    for (int s = 0; s < 2; s++) begin
      bus_wr(`ADDR_EDGE_CTL, s ? 32'h100 : 32'h0);
      bounce <= 2'(next_rand());
      e = exc_count;
      press <= 1'b1;
      cycles(8);
      expect_reg("pin_low", `ADDR_EDGE_CTL, s ? 32'h100 : 32'h0);
      chk("exc_fall", e + (s ? 0 : 1), exc_count);
      press <= 1'b0;
      cycles(8);
      chk("exc_rise", e + 1, exc_count);
    end
    expect_reg("edge_ctl", `ADDR_EDGE_CTL, 32'h8100);
    bus_wr(`ADDR_EDGE_CTL, 32'h0);
    // Interval mode from random start values near overflow.
    for (int k = 0; k < 4; k++) begin
      v = 8'hE0 | 8'(next_rand() & 32'h1F);
      bus_wr(`ADDR_STAB_CNT, {24'h0, v});
      bus_wr(`ADDR_WDT_CSR, 32'h20);
      n = 0;
      while (ivl_ovf !== 1'b1 && n < 300) begin
        @(posedge core_clk_in);
        #1 n++;
      end
      chk("ivl_time", 1, n >= 255 - v && n <= 259 - v);
      bus_wr(`ADDR_WDT_CSR, 32'h00);
    end
    chk("no_wdt_reset", 0, rst_count);
    bus_wr(`ADDR_STAB_CNT, 32'h5A);
    cycles(20);
    expect_reg("halted", `ADDR_STAB_CNT, 32'h5A);
    // A write while the clock enable is low must not land.
    clk_en_in <= 1'b0;
    bus_wr(`ADDR_STAB_CNT, 32'h11);
    clk_en_in <= 1'b1;
    expect_reg("frozen", `ADDR_STAB_CNT, 32'h5A);
    bus_wr(`ADDR_STAB_CNT, 32'hF8);
    bus_wr(`ADDR_WDT_CSR, 32'h60);
    cycles(20);
    bus_wr(`ADDR_WDT_CSR, 32'h00);
    chk("wdt_reset", 1, rst_count);
    // Entry refused while the counter runs.
    bus_wr(`ADDR_STBY_CTL, 32'h80);
    bus_wr(`ADDR_WDT_CSR, 32'h20);
    sleep_now();
    expect_reg("refused", `ADDR_STBY_STAT, 32'h11);
    bus_wr(`ADDR_STBY_STAT, 32'h10);
    expect_reg("ref_clear", `ADDR_STBY_STAT, 32'h01);
    // Full standby cycle woken by the pin.
    // Stop the timer first so the preset start value is not counted away.
    bus_wr(`ADDR_WDT_CSR, 32'h06);
    bus_wr(`ADDR_STAB_CNT, 32'hF0);
    sleep_now();
    chk("standby_pwr", 32'h02, 32'(power));
    expect_reg("st_standby", `ADDR_STBY_STAT, 32'h04);
    bus_wr(`ADDR_STAB_CNT, 32'h11);
    bus_wr(`ADDR_WDT_CSR, 32'h20);
    expect_reg("cnt_kept", `ADDR_STAB_CNT, 32'hF0);
    expect_reg("wdt_kept", `ADDR_WDT_CSR, 32'h06);
    e = exc_count;
    press <= 1'b1;
    cycles(8);
    chk("stab_pwr", 32'h12, 32'(power));
    wait_run(1500, n);
    chk("wake_time", 1, n + 8 >= wake_cycles(8'hF0, 6) - 64
        && n + 8 <= wake_cycles(8'hF0, 6) + 16);
    cycles(2);
    chk("run_pwr", 32'h18, 32'(power));
    chk("wake_exc", e + 1, exc_count);
    expect_reg("cnt_wrap", `ADDR_STAB_CNT, 32'h00);
    press <= 1'b0;
    cycles(8);
    // Each IRQ group blocked in turn; floating pins this time.
    for (int g = 0; g < 2; g++) begin
      idx = 4 * g + int'(next_rand() & 32'h3);
      bus_wr(`ADDR_STAB_CNT, 32'hFE);
      bus_wr(`ADDR_WDT_CSR, 32'h00);
      bus_wr(`ADDR_STBY_CTL, g ? 32'hC2 : 32'hC1);
      sleep_now();
      chk("float_pwr", 32'h01, 32'(power));
      irq_pin <= 8'(1 << idx);
      cycles(20);
      expect_reg("blocked", `ADDR_STBY_STAT, 32'h04);
      irq_pin <= 8'(1 << (idx ^ 4));
      wait_run(50, n);
      chk("irq_wake", 32'h18, 32'(power));
      irq_pin <= 8'h00;
      cycles(8);
    end
    chk("no_pin_exc", e + 1, exc_count);
    // Ordinary sleep keeps the oscillator and wakes on any IRQ.
    bus_wr(`ADDR_STBY_CTL, 32'h00);
    sleep_now();
    chk("sleep_pwr", 32'h14, 32'(power));
    irq_pin <= 8'h10;
    wait_run(50, n);
    expect_reg("sleep_exit", `ADDR_STBY_STAT, 32'h01);
    conclude();
  end
endmodule : test_standby_entry_wake_control
